// >>> core/ddi_device.sv
`timescale 1ns/100ps
module ddi_device
	import ddi_pkg::*;
#(
	parameter int ROW_W = ROW_W_DEF,
	parameter int COL_W = COL_W_DEF
) (
	ddi_link_if.device             link,
	input  wire logic              reset,
	output logic [1:0]             burst_code,
	output logic [BANK_W-1:0]      refresh_bank,
	output logic [ROW_W-1:0]       refresh_row
);

	localparam int WORD_W = BANK_W + ROW_W + COL_W;
	localparam int WORDS  = 1 << WORD_W;

	// ****************************************
	// Parameter checks
	// ****************************************
	if (ROW_W + COL_W != ADDR_W) begin : g_bad_addr
		$error("ddi_device: ROW_W + COL_W must equal the link address width");
	end
	if (COL_W < 3) begin : g_bad_col
		$error("ddi_device: COL_W below 3 cannot hold an eight beat burst");
	end

	// ****************************************
	// Declarations
	// ****************************************
	logic                ck;
	logic [DQ_W-1:0]     mem [WORDS];
	logic                cmd_live;
	logic [1:0]          cmd_code;
	logic                cmd_read;
	logic                cmd_write;
	logic                cmd_refresh;
	logic                cmd_mode;
	logic                busy;
	logic [1:0]          last_pair;
	logic [BANK_W-1:0]   acc_bank;
	logic [ROW_W-1:0]    acc_row;
	logic [COL_W-1:0]    acc_col;
	logic                wr_stage;
	logic                wr_act;
	logic                rd_act;
	logic [1:0]          idx;
	logic [COL_W-1:0]    even_col;
	logic [COL_W-1:0]    odd_col;
	logic [ROW_W-1:0]    refresh_ptr [BANKS];
	logic [DQ_W-1:0]     wr_even;
	logic [DQ_W-1:0]     wr_odd;
	logic [DQ_W:0]       even_beat;
	logic [DQ_W:0]       odd_beat;
	logic [DQ_W:0]       odd_hold;
	logic [DQ_W:0]       rise_reg;
	logic [DQ_W:0]       fall_reg;

	function automatic logic [WORD_W-1:0] word_at(
		input logic [BANK_W-1:0] b,
		input logic [ROW_W-1:0]  r,
		input logic [COL_W-1:0]  c
	);
		word_at = {b, r, c};
	endfunction

	// The device runs on the command clock from the link, except write data capture on the write data clock
	assign ck = link.command_clock;

	// ****************************************
	// Command decode
	// ****************************************
	// Decoded combinationally but read only by rising-edge flops
	assign cmd_live    = !link.cmd_sel_n;
	assign cmd_code    = {link.write_en_n, link.refresh_n};
	assign cmd_read    = cmd_live && (cmd_code == CMD_READ); // R4
	assign cmd_write   = cmd_live && (cmd_code == CMD_WRITE); // R4
	assign cmd_refresh = cmd_live && (cmd_code == CMD_REFRESH); // R4
	assign cmd_mode    = cmd_live && (cmd_code == CMD_MODE); // R4
	assign busy        = wr_stage || wr_act || rd_act;
	assign last_pair   = 2'((ddi_beats(burst_code) >> 1) - 4'h1);

	// ****************************************
	// Mode setting
	// ****************************************
	// Mode commands during a burst, or with the unused code, are dropped
	always_ff @(posedge ck or posedge reset) begin
		if (reset) begin
			burst_code <= BL_RESET;
		end else if (cmd_mode && !busy && link.addr[1:0] != BL_CODE_BAD) begin
			burst_code <= link.addr[1:0]; // R6
		end
	end

	// ****************************************
	// Per-bank refresh
	// ****************************************
	// Only the bank comes from the link; the row walks inside each bank
	always_ff @(posedge ck or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < BANKS; i++) begin
				refresh_ptr[i] <= '0;
			end
			refresh_bank <= '0;
			refresh_row  <= '0;
		end else if (cmd_refresh) begin
			refresh_ptr[link.bank] <= refresh_ptr[link.bank] + 1'b1; // R7
			refresh_bank           <= link.bank; // R7
			refresh_row            <= refresh_ptr[link.bank]; // R7
		end
	end

	// ****************************************
	// Access sequencing
	// ****************************************
	// One access at a time; read and write commands while busy are dropped
	always_ff @(posedge ck or posedge reset) begin
		if (reset) begin
			acc_bank <= '0;
			acc_row  <= '0;
			acc_col  <= '0;
			wr_stage <= 1'b0;
			wr_act   <= 1'b0;
			rd_act   <= 1'b0;
			idx      <= '0;
		end else begin
			wr_stage <= 1'b0;
			if (!busy && (cmd_read || cmd_write)) begin
				acc_bank <= link.bank; // R1
				acc_row  <= link.addr[COL_W +: ROW_W];
				acc_col  <= link.addr[COL_W-1:0];
			end
			if (!busy && cmd_write) begin
				wr_stage <= 1'b1;
			end
			if (!busy && cmd_read) begin
				rd_act <= 1'b1;
				idx    <= '0;
			end
			if (wr_stage) begin
				wr_act <= 1'b1;
				idx    <= '0;
			end
			if (wr_act || rd_act) begin
				idx <= idx + 2'h1;
				if (idx == last_pair) begin // R6
					wr_act <= 1'b0;
					rd_act <= 1'b0;
				end
			end
		end
	end

	assign even_col = acc_col + COL_W'({idx, 1'b0});
	assign odd_col  = acc_col + COL_W'({idx, 1'b1});

	// ****************************************
	// Write data capture
	// ****************************************
	// The write clocks share the command clock's frequency with a quarter
	// period offset, so each captured pair is stable for a half period
	// around the command clock rise that stores it.
	always_ff @(posedge link.write_data_clock or posedge reset) begin
		if (reset) begin
			wr_even <= '0;
		end else begin
			wr_even <= link.dq; // R5 R2
		end
	end

	always_ff @(negedge link.write_data_clock or posedge reset) begin
		if (reset) begin
			wr_odd <= '0;
		end else begin
			wr_odd <= link.dq; // R5 R2
		end
	end

	// Array holds data only, so it takes no reset
	always_ff @(posedge ck) begin
		if (wr_act) begin
			mem[word_at(acc_bank, acc_row, even_col)] <= wr_even; // R1
			mem[word_at(acc_bank, acc_row, odd_col)]  <= wr_odd;
		end
	end

	// ****************************************
	// Read data launch
	// ****************************************
	assign even_beat = rd_act ? {1'b1, mem[word_at(acc_bank, acc_row, even_col)]} : '0;
	assign odd_beat  = rd_act ? {1'b1, mem[word_at(acc_bank, acc_row, odd_col)]} : '0;

	// Two flops joined by an exclusive-or give a double-rate output
	// without a clock-driven multiplexer: each edge stores its beat
	// folded with the other flop, so the combined value is that beat.
	always_ff @(posedge ck or posedge reset) begin
		if (reset) begin
			rise_reg <= '0;
			odd_hold <= '0;
		end else begin
			rise_reg <= even_beat ^ fall_reg; // R2
			odd_hold <= odd_beat;
		end
	end

	always_ff @(negedge ck or posedge reset) begin
		if (reset) begin
			fall_reg <= '0;
		end else begin
			fall_reg <= odd_hold ^ rise_reg; // R2
		end
	end

	assign {link.read_valid, link.dev_dq_out} = rise_reg ^ fall_reg;
	assign link.dev_dq_oe                     = link.read_valid;

	// ****************************************
	// Read data clocks
	// ****************************************
	// Every group's clock is the command clock forwarded, so beats change
	// on its edges. Group g belongs to pair g mod 2, which is why pairs
	// zero and one alone still cover all lanes.
	for (genvar g = 0; g < GROUPS; g++) begin : g_read_clock
		assign link.read_data_clock[g]   = ck; // R3 R8 R9
		assign link.read_data_clock_n[g] = ~ck; // R8
	end

endmodule

// >>> core/ddi_host.sv
`timescale 1ns/100ps
module ddi_host
	import ddi_pkg::*;
(
	ddi_link_if.host                     link,
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    req_valid,
	output logic                         req_ready,
	input  wire ddi_op_t                 req_op,
	input  wire logic [BANK_W-1:0]       req_bank,
	input  wire logic [ADDR_W-1:0]       req_addr,
	input  wire logic [MAX_BEATS*DQ_W-1:0] req_wdata,
	output logic                         rsp_valid,
	output logic [MAX_BEATS*DQ_W-1:0]    rsp_rdata,
	output logic [1:0]                   burst_code
);

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_WRITE = 2'b01,
		HS_READ  = 2'b10
	} ddi_hstate_t;

	ddi_hstate_t                state;
	logic [PH_W-1:0]            ph;
	logic [PH_W-1:0]            next_ph;
	logic                       ck;
	logic                       wdk;
	logic                       cmd_edge;
	logic                       half_edge;
	logic                       accept;
	logic [3:0]                 sl;
	logic [3:0]                 beat_no;
	logic [MAX_BEATS*DQ_W-1:0]  wbuf;
	logic [USED_READ_PAIRS-1:0] tog;
	logic [USED_READ_PAIRS-1:0] tog_s1;
	logic [USED_READ_PAIRS-1:0] tog_s2;
	logic [USED_READ_PAIRS-1:0] tog_seen;
	wire  [MAX_BEATS*DQ_W-1:0]  assembled;

	// ****************************************
	// Link clock divider
	// ****************************************
	assign next_ph   = ph + 1'b1;
	assign cmd_edge  = (next_ph == PH_HALF);
	assign half_edge = cmd_edge || (next_ph == '0);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// Last phase, so the first link clock high phase after reset is full length
			ph  <= '1;
			ck  <= 1'b0;
			wdk <= 1'b0;
		end else begin
			ph  <= next_ph;
			ck  <= (next_ph < PH_HALF);
			wdk <= (next_ph >= PH_WDK_ON) && (next_ph < PH_WDK_OFF);
		end
	end

	assign link.command_clock      = ck;
	assign link.command_clock_n    = ~ck;
	assign link.write_data_clock   = wdk; // R5
	assign link.write_data_clock_n = ~wdk;

	// ****************************************
	// Command launch
	// ****************************************
	// Launched on the command clock fall so it is centred on the rise
	assign req_ready = (state == HS_IDLE) && cmd_edge;
	assign accept    = req_valid && req_ready;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.cmd_sel_n  <= 1'b1;
			link.write_en_n <= 1'b1;
			link.refresh_n  <= 1'b1;
			link.bank       <= '0;
			link.addr       <= '0;
		end else if (cmd_edge) begin
			link.cmd_sel_n  <= !accept; // R4
			link.write_en_n <= 1'b1;
			link.refresh_n  <= 1'b1;
			if (accept) begin
				link.bank <= req_bank;
				link.addr <= req_addr;
				unique case (req_op)
					OP_READ:    {link.write_en_n, link.refresh_n} <= CMD_READ;
					OP_WRITE:   {link.write_en_n, link.refresh_n} <= CMD_WRITE;
					OP_REFRESH: {link.write_en_n, link.refresh_n} <= CMD_REFRESH;
					OP_MODE:    {link.write_en_n, link.refresh_n} <= CMD_MODE;
				endcase
			end
		end
	end

	// Unused mode code is still sent on the link; only the local burst length ignores it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			burst_code <= BL_RESET;
		end else if (accept && req_op == OP_MODE && req_addr[1:0] != BL_CODE_BAD) begin
			burst_code <= req_addr[1:0]; // R11
		end
	end

	// ****************************************
	// Sequencer and write data
	// ****************************************
	assign beat_no = sl - WR_LEAD_SLOTS;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state            <= HS_IDLE;
			sl               <= '0;
			wbuf             <= '0;
			link.host_dq_out <= '0;
			link.host_dq_oe  <= 1'b0;
			rsp_valid        <= 1'b0;
			rsp_rdata        <= '0;
			tog_seen         <= '0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state)
				HS_IDLE: begin
					sl <= '0;
					if (accept && req_op == OP_WRITE) begin
						state <= HS_WRITE;
						wbuf  <= req_wdata;
					end
					if (accept && req_op == OP_READ) begin
						state <= HS_READ;
					end
				end
				HS_WRITE: begin
					if (half_edge) begin
						sl <= sl + 4'h1;
						if (sl >= WR_LEAD_SLOTS && beat_no < ddi_beats(burst_code)) begin
							link.host_dq_out <= wbuf[3'(beat_no)*DQ_W +: DQ_W]; // R2
							link.host_dq_oe  <= 1'b1;
						end else if (sl >= WR_LEAD_SLOTS) begin
							link.host_dq_oe <= 1'b0;
							state           <= HS_IDLE;
						end
					end
				end
				HS_READ: begin
					if ((tog_s2 ^ tog_seen) == '1) begin
						tog_seen  <= tog_s2;
						rsp_rdata <= assembled;
						rsp_valid <= 1'b1;
						state     <= HS_IDLE;
					end
				end
				default: begin
					state <= HS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tog_s1 <= '0;
			tog_s2 <= '0;
		end else begin
			tog_s1 <= tog;
			tog_s2 <= tog_s1;
		end
	end

	// ****************************************
	// Read capture on pairs zero and one
	// ****************************************
	// Beats are taken one edge after launch: even on the fall, odd on the
	// next rise. The buffers stay still until the toggle has been seen,
	// since no new read is sent before the answer.
	for (genvar p = 0; p < USED_READ_PAIRS; p++) begin : g_cap
		logic [2*GROUP_W-1:0] lanes;
		logic [2*GROUP_W-1:0] fbuf [MAX_BEATS/2];
		logic [2*GROUP_W-1:0] rbuf [MAX_BEATS/2];
		logic [1:0]           fcnt;
		logic [1:0]           rcnt;
		logic                 pend;
		logic                 done_tog;

		assign lanes = {link.dq[(p+2)*GROUP_W +: GROUP_W], link.dq[p*GROUP_W +: GROUP_W]}; // R9
		assign tog[p] = done_tog;

		always_ff @(negedge link.read_data_clock[p] or posedge reset) begin
			if (reset) begin
				fcnt <= '0;
			end else begin
				fcnt <= link.read_valid ? fcnt + 2'h1 : 2'h0;
			end
		end

		always_ff @(negedge link.read_data_clock[p]) begin
			if (link.read_valid) begin
				fbuf[fcnt] <= lanes; // R3 R10
			end
		end

		always_ff @(posedge link.read_data_clock[p] or posedge reset) begin
			if (reset) begin
				rcnt     <= '0;
				pend     <= 1'b0;
				done_tog <= 1'b0;
			end else if (link.read_valid) begin
				rcnt <= rcnt + 2'h1;
				pend <= 1'b1;
			end else begin
				rcnt <= '0;
				pend <= 1'b0;
				if (pend) begin
					done_tog <= !done_tog;
				end
			end
		end

		always_ff @(posedge link.read_data_clock[p]) begin
			if (link.read_valid) begin
				rbuf[rcnt] <= lanes; // R3 R10
			end
		end

		for (genvar b = 0; b < MAX_BEATS; b++) begin : g_beat
			if (b % 2 == 0) begin : g_even
				assign assembled[b*DQ_W + p*GROUP_W +: GROUP_W]     = fbuf[b/2][0 +: GROUP_W];
				assign assembled[b*DQ_W + (p+2)*GROUP_W +: GROUP_W] = fbuf[b/2][GROUP_W +: GROUP_W];
			end else begin : g_odd
				assign assembled[b*DQ_W + p*GROUP_W +: GROUP_W]     = rbuf[b/2][0 +: GROUP_W];
				assign assembled[b*DQ_W + (p+2)*GROUP_W +: GROUP_W] = rbuf[b/2][GROUP_W +: GROUP_W];
			end
		end
	end

endmodule

// >>> core/ddi_link_if.sv
`timescale 1ns/100ps
interface ddi_link_if;
	import ddi_pkg::*;

	logic              command_clock;
	logic              command_clock_n;
	logic              write_data_clock;
	logic              write_data_clock_n;
	logic [GROUPS-1:0] read_data_clock;
	logic [GROUPS-1:0] read_data_clock_n;
	logic              cmd_sel_n;
	logic              write_en_n;
	logic              refresh_n;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0]   host_dq_out;
	logic              host_dq_oe;
	logic [DQ_W-1:0]   dev_dq_out;
	logic              dev_dq_oe;
	logic              read_valid;
	logic [DQ_W-1:0]   dq;

	// Shared data balls; an undriven bus reads as zero
	assign dq = host_dq_oe ? host_dq_out : (dev_dq_oe ? dev_dq_out : '0);

	modport device (
		input  command_clock, command_clock_n, write_data_clock, write_data_clock_n,
		input  cmd_sel_n, write_en_n, refresh_n, bank, addr, dq,
		output read_data_clock, read_data_clock_n, dev_dq_out, dev_dq_oe, read_valid
	);

	modport host (
		output command_clock, command_clock_n, write_data_clock, write_data_clock_n,
		output cmd_sel_n, write_en_n, refresh_n, bank, addr, host_dq_out, host_dq_oe,
		input  read_data_clock, read_data_clock_n, read_valid, dq
	);

endinterface

// >>> core/ddi_pkg.sv
// What this block does
// R1: Sixteen banks, chosen by bank address per command
// R2: Two data bits per ball per clock
// R3: Read data aligned to device read clocks
// R4: Commands sampled only on command clock rise
// R5: Write data captured on both write-clock edges
// R6: Burst length 2, 4 or 8 via mode
// R7: Per-bank refresh, row counter kept inside device
// R8: Four read clock pairs, nine lanes each
// R9: Pair zero: lanes 8:0, 26:18; pair one: rest
// R10: Two-pair controller uses pairs zero and one
// R11: Controller issues only defined commands and modes; the host still sends the unused mode code
package ddi_pkg;

	// ****************************************
	// Array shape
	// ****************************************
	localparam int BANKS     = 16;
	localparam int BANK_W    = 4;
	localparam int GROUPS    = 4;
	localparam int GROUP_W   = 9;
	localparam int DQ_W      = GROUPS * GROUP_W;
	localparam int MAX_BEATS = 8;
	localparam int ROW_W_DEF = 4;
	localparam int COL_W_DEF = 3;
	localparam int ADDR_W    = ROW_W_DEF + COL_W_DEF;
	localparam int USED_READ_PAIRS = 2;

	// ****************************************
	// Commands as {write_en_n, refresh_n} with select low
	// ****************************************
	localparam logic [1:0] CMD_READ    = 2'h3;
	localparam logic [1:0] CMD_WRITE   = 2'h1;
	localparam logic [1:0] CMD_REFRESH = 2'h2;
	localparam logic [1:0] CMD_MODE    = 2'h0;

	// ****************************************
	// Burst length codes carried on addr[1:0] of a mode command
	// ****************************************
	localparam logic [1:0] BL_CODE_2   = 2'h0;
	localparam logic [1:0] BL_CODE_4   = 2'h1;
	localparam logic [1:0] BL_CODE_8   = 2'h2;
	localparam logic [1:0] BL_CODE_BAD = 2'h3;
	localparam logic [1:0] BL_RESET    = BL_CODE_2;

	// ****************************************
	// Link timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 8;
	localparam int LINK_PERIOD_NS = 32;
	localparam int CK_DIV         = LINK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PH_W           = $clog2(CK_DIV);
	localparam logic [PH_W-1:0] PH_HALF    = PH_W'(CK_DIV / 2);
	localparam logic [PH_W-1:0] PH_WDK_ON  = PH_W'(CK_DIV / 4);
	localparam logic [PH_W-1:0] PH_WDK_OFF = PH_W'(CK_DIV * 3 / 4);
	// Half periods between the command clock rise that takes a write and its first beat
	localparam logic [3:0] WR_LEAD_SLOTS = 4'h2;

	typedef enum logic [1:0] {
		OP_READ    = 2'h0,
		OP_WRITE   = 2'h1,
		OP_REFRESH = 2'h2,
		OP_MODE    = 2'h3
	} ddi_op_t;

	function automatic logic [3:0] ddi_beats(input logic [1:0] code);
		unique case (code)
			BL_CODE_2: ddi_beats = 4'h2;
			BL_CODE_4: ddi_beats = 4'h4;
			default:   ddi_beats = 4'h8;
		endcase
	endfunction

endpackage

// >>> verification/ddi_link_asserts.sv
`timescale 1ns/100ps
module ddi_link_asserts
	import ddi_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              command_clock,
	input wire logic              command_clock_n,
	input wire logic              write_data_clock,
	input wire logic              write_data_clock_n,
	input wire logic [GROUPS-1:0] read_data_clock,
	input wire logic [GROUPS-1:0] read_data_clock_n,
	input wire logic              cmd_sel_n,
	input wire logic              write_en_n,
	input wire logic              refresh_n,
	input wire logic [BANK_W-1:0] bank,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              host_dq_oe,
	input wire logic              dev_dq_oe,
	input wire logic              read_valid
);

	// ****************************************
	// Run lengths of the two data windows
	// ****************************************
	logic [4:0] rv_run;
	logic [4:0] wr_run;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rv_run <= 5'h00;
		end else if (read_valid) begin
			rv_run <= rv_run + 5'h01;
		end else begin
			rv_run <= 5'h00;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_run <= 5'h00;
		end else if (host_dq_oe) begin
			wr_run <= wr_run + 5'h01;
		end else begin
			wr_run <= 5'h00;
		end
	end

	// ****************************************
	// Link rules
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_write_cmd;
		$fell(cmd_sel_n) && !write_en_n && refresh_n;
	endsequence

	sequence s_read_cmd;
		$fell(cmd_sel_n) && write_en_n && refresh_n;
	endsequence

	sequence s_ck_cycle;
		command_clock[*2] ##1 !command_clock[*2] ##1 command_clock;
	endsequence

	a_ck_period: assert property ($rose(command_clock) |-> s_ck_cycle)
		else $error("command clock period wrong");
	a_ck_complement: assert property (command_clock_n == !command_clock
		&& write_data_clock_n == !write_data_clock)
		else $error("clock pairs not complementary");
	a_rdclk_copy: assert property (read_data_clock == {GROUPS{command_clock}}
		&& read_data_clock_n == ~read_data_clock)
		else $error("read clocks not following command clock");
	a_wdk_lag: assert property (write_data_clock == $past(command_clock))
		else $error("write clock not one cycle behind");
	a_cmd_held: assert property ($fell(cmd_sel_n) |-> (!cmd_sel_n)[*4])
		else $error("command select not held a link period");
	a_cmd_stable: assert property ($rose(command_clock) |-> $stable(cmd_sel_n)
		&& $stable(write_en_n) && $stable(refresh_n) && $stable(bank) && $stable(addr))
		else $error("command lines moved at clock rise");
	a_dq_excl: assert property (!(host_dq_oe && dev_dq_oe))
		else $error("both ends drive the data balls");
	a_write_lead: assert property (s_write_cmd |-> ##6 $rose(host_dq_oe))
		else $error("write data window late or early");
	a_read_lead: assert property (s_read_cmd |-> ##6 $rose(read_valid))
		else $error("read data window late or early");
	a_read_len: assert property ($fell(read_valid) |->
		(rv_run == 5'h04 || rv_run == 5'h08 || rv_run == 5'h10))
		else $error("read burst length not 2, 4 or 8");
	a_write_len: assert property ($fell(host_dq_oe) |->
		(wr_run == 5'h04 || wr_run == 5'h08 || wr_run == 5'h10))
		else $error("write burst length not 2, 4 or 8");

endmodule

// >>> verification/ddr_multibank_dram_interface_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ddr_multibank_dram_interface_tb;
	import ddi_pkg::*;

	logic                      clk;
	logic                      reset;
	logic                      req_valid;
	logic                      req_ready;
	ddi_op_t                   req_op;
	logic [BANK_W-1:0]         req_bank;
	logic [ADDR_W-1:0]         req_addr;
	logic [MAX_BEATS*DQ_W-1:0] req_wdata;
	logic                      rsp_valid;
	logic [MAX_BEATS*DQ_W-1:0] rsp_rdata;
	logic [1:0]                host_code;
	logic [1:0]                dev_code;
	logic [BANK_W-1:0]         refresh_bank;
	logic [ROW_W_DEF-1:0]      refresh_row;
	logic [DQ_W-1:0]           mem [BANKS][2**ADDR_W];
	logic [1:0]                codes [3];
	int                        err_total;
	int                        n_tests;
	int                        i;

	// ****************************************
	// Both ends across one link
	// ****************************************
	ddi_link_if lnk ();

	ddi_device ddi_device_inst (.link(lnk), .reset(reset), .burst_code(dev_code),
		.refresh_bank(refresh_bank), .refresh_row(refresh_row));

	ddi_host ddi_host_inst (.link(lnk), .clk(clk), .reset(reset), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.burst_code(host_code));

	ddi_link_asserts ddi_link_asserts_inst (.clk(clk), .reset(reset),
		.command_clock(lnk.command_clock), .command_clock_n(lnk.command_clock_n),
		.write_data_clock(lnk.write_data_clock), .read_data_clock(lnk.read_data_clock),
		.write_data_clock_n(lnk.write_data_clock_n),
		.read_data_clock_n(lnk.read_data_clock_n), .cmd_sel_n(lnk.cmd_sel_n),
		.write_en_n(lnk.write_en_n), .refresh_n(lnk.refresh_n), .bank(lnk.bank),
		.addr(lnk.addr), .host_dq_oe(lnk.host_dq_oe), .dev_dq_oe(lnk.dev_dq_oe),
		.read_valid(lnk.read_valid));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Lanes of every nine-bit group differ so a swapped read clock pair shows up
	function automatic logic [DQ_W-1:0] pat(input int b, input int a, input int k);
		return {4'(b), 7'(a), 4'(k), ~4'(b), ~7'(a), 10'h2A5};
	endfunction

	function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] a, input int k);
		return {a[6:3], 3'(a[2:0] + k)};
	endfunction

	task automatic send(input ddi_op_t op, input logic [3:0] b, input logic [6:0] a);
		int k;
		@(negedge clk);
		req_op = op;
		req_bank = b;
		req_addr = a;
		req_valid = 1'b1;
		// Ready decodes registers only, so it stands from this fall to the rise that takes it
		for (k = 0; k < 80 && req_ready !== 1'b1; k++) @(negedge clk);
		if (k == 80) begin
			err_total++;
			give_verdict();
		end
		@(negedge clk);
		req_valid = 1'b0;
	endtask

	task automatic wr(input logic [3:0] b, input logic [6:0] a, input int bl);
		int k;
		for (k = 0; k < MAX_BEATS; k++) begin
			req_wdata[k*DQ_W +: DQ_W] = pat(b, a, k);
			if (k < bl) mem[b][beat_addr(a, k)] = pat(b, a, k);
		end
		send(OP_WRITE, b, a);
	endtask

	task automatic rd(input logic [3:0] b, input logic [6:0] a, input int bl);
		int k;
		send(OP_READ, b, a);
		for (k = 0; k < 200 && rsp_valid !== 1'b1; k++) @(negedge clk);
		if (k == 200) begin
			err_total++;
			give_verdict();
		end
		for (k = 0; k < bl; k++) begin
			`CHK(rsp_rdata[k*DQ_W +: DQ_W], mem[b][beat_addr(a, k)])
		end
	endtask

	task automatic set_bl(input logic [1:0] c);
		int k;
		send(OP_MODE, 4'h0, {5'h00, c});
		for (k = 0; k < 40 && !(dev_code === c && host_code === c); k++) @(negedge clk);
		`CHK(dev_code, c)
		`CHK(host_code, c)
	endtask

	task automatic chk_ref(input logic [3:0] b, input logic [ROW_W_DEF-1:0] r);
		int k;
		send(OP_REFRESH, b, 7'h7F);
		for (k = 0; k < 40 && !(refresh_bank === b && refresh_row === r); k++) @(negedge clk);
		`CHK(refresh_bank, b)
		`CHK(refresh_row, r)
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		err_total = 0;
		n_tests = 0;
		reset = 1'b1;
		req_valid = 1'b0;
		req_op = OP_READ;
		req_bank = 4'h0;
		req_addr = 7'h00;
		req_wdata = '0;
		codes = '{BL_CODE_8, BL_CODE_4, BL_CODE_2};
		repeat (8) @(negedge clk);
		reset = 1'b0;
		`CHK(host_code, BL_RESET)
		`CHK(dev_code, BL_RESET)
		// Every bank keeps its own word at a different address, i*9
		for (i = 0; i < BANKS; i++) wr(4'(i), 7'(i * 9), 2);
		for (i = 0; i < BANKS; i++) rd(4'(i), 7'(i * 9), 2);
		// Longest burst first fills the row, length 4 then wraps over its end and length 2 ends on it
		for (i = 0; i < 3; i++) begin
			set_bl(codes[i]);
			wr(4'h7, 7'h16, 8 >> i);
			rd(4'h7, 7'h16, 8 >> i);
			rd(4'h7, 7'h10, 8 >> i);
		end
		// An undefined burst code must leave length 2 in force at both ends
		send(OP_MODE, 4'h0, {5'h00, BL_CODE_BAD});
		rd(4'h7, 7'h10, 2);
		`CHK(dev_code, BL_CODE_2)
		`CHK(host_code, BL_CODE_2)
		chk_ref(4'h5, 4'h0);
		chk_ref(4'h5, 4'h1);
		chk_ref(4'h3, 4'h0);
		give_verdict();
	end

endmodule
